/* File: core/arf_host.sv */
// Contract
// - Strobe rising edge captures new result
// - Inverted strobe edge captures previous result
// - Flag AND top bit gives range
// - Twos complement uses inverted top bit
// - Straight bipolar: subtract 2048 for sign
// - Host supplies one trigger per sample
//
// Host controller: issues conversion triggers, captures result on strobe edges
// Assumes device pins arrive asynchronously; one clock, synchronous reset
`timescale 1ns/1ps
`include "arf_cfg.svh"
module arf_host
   import arf_pkg::*;
#(
   parameter int TRIG_CYC = `ARF_TRIG_CYC,
   parameter logic [15:0] TIMEOUT = `ARF_TIMEOUT
)
(
   input  wire logic                  clock_i,
   input  wire logic                  rstn_i,
   input  wire logic                  start_i,
   input  wire logic                  result_valid_strobe_i,
   input  wire logic [`ARF_RES_W-1:0] data_i,
   input  wire logic                  data_top_n_i,
   input  wire logic                  range_violation_flag_i,
   output logic                       conversion_trigger_o,
   output logic                       busy_o,
   output logic                       new_valid_o,
   output arf_pkg::arf_result_t       new_res_o,
   output arf_pkg::arf_pins_t         prev_o,
   output logic                       timeout_o
);
   import arf_pkg::*;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_TRIG = 3'b010,
      ST_WAIT = 3'b100
   } arf_state_t;

   typedef struct packed
   {
      arf_state_t  state;
      logic [1:0]  strb_sync;
      arf_pins_t   pin_s1;
      arf_pins_t   pin_s2;
      logic        strb_d;
      logic [7:0]  tcnt;
      logic [15:0] wcnt;
      logic        trig;
      logic        nvalid;
      arf_pins_t   cap;
      arf_pins_t   prev;
      logic        tout;
      logic        busy;
      arf_result_t res;
   } arf_host_st_t;

   arf_host_st_t st_ff;
   arf_host_st_t nxt_st;
   arf_result_t  dec_res;
   arf_pins_t    pin_now;
   logic         rise;
   logic         fall;

   assign pin_now = '{bits: data_i, top_n: data_top_n_i, flag: range_violation_flag_i};
   assign rise    = st_ff.strb_sync[1] & ~st_ff.strb_d;
   assign fall    = ~st_ff.strb_sync[1] & st_ff.strb_d;

   // Decode the word about to be captured so the result lands in a flop
   arf_decode u_dec
   (
      .pins_i (st_ff.pin_s2),
      .res_o  (dec_res)
   );

   always_comb
   begin
      nxt_st           = st_ff;
      // Data takes two stages so it lines up with the strobe edge
      nxt_st.strb_sync = {st_ff.strb_sync[0], result_valid_strobe_i};
      nxt_st.pin_s1    = pin_now;
      nxt_st.pin_s2    = st_ff.pin_s1;
      nxt_st.strb_d    = st_ff.strb_sync[1];
      nxt_st.nvalid    = 1'b0;
      if (rise)
      begin
         nxt_st.cap    = st_ff.pin_s2;
         nxt_st.res    = dec_res;
         nxt_st.nvalid = 1'b1;
      end
      // Inverted strobe: word before the next update
      if (fall)
         nxt_st.prev = st_ff.pin_s2;
      case (st_ff.state)
         ST_IDLE:
         begin
            if (start_i)
            begin
               nxt_st.state = ST_TRIG;
               nxt_st.trig  = 1'b1;
               nxt_st.tcnt  = 8'h00;
               nxt_st.tout  = 1'b0;
            end
         end
         ST_TRIG:
         begin
            nxt_st.tcnt = st_ff.tcnt + 8'h01;
            if (st_ff.tcnt >= 8'(TRIG_CYC - 1))
            begin
               nxt_st.trig  = 1'b0;
               nxt_st.state = ST_WAIT;
               nxt_st.wcnt  = 16'h0000;
            end
         end
         ST_WAIT:
         begin
            nxt_st.wcnt = st_ff.wcnt + 16'h0001;
            // Every conversion ends in a strobe; a missing one is reported
            if (rise)
               nxt_st.state = ST_IDLE;
            else if (st_ff.wcnt >= TIMEOUT)
            begin
               nxt_st.tout  = 1'b1;
               nxt_st.state = ST_IDLE;
            end
         end
         default:
            nxt_st.state = ST_IDLE;
      endcase
      // Busy follows the next state so the pin is a flop output
      nxt_st.busy = nxt_st.state != ST_IDLE;
   end

   always_ff @(posedge clock_i)
   begin
      if (!rstn_i)
      begin
         st_ff       <= '0;
         st_ff.state <= ST_IDLE;
      end
      else
         st_ff <= nxt_st;
   end

   assign conversion_trigger_o = st_ff.trig;
   assign busy_o               = st_ff.busy;
   assign new_valid_o          = st_ff.nvalid;
   assign prev_o               = st_ff.prev;
   assign timeout_o            = st_ff.tout;
   // Decoded word registered at capture; no logic after the flop
   assign new_res_o            = st_ff.res;

   sequence s_trig_pulse;
      conversion_trigger_o [*2] ##1 !conversion_trigger_o;
   endsequence
   property p_trig_width;
      @(posedge clock_i) disable iff (!rstn_i)
      $rose(conversion_trigger_o) |-> s_trig_pulse;
   endproperty
   a_trig_width: assert property (p_trig_width) else $error("trigger width wrong");

   sequence s_word_taken;
      new_valid_o && (st_ff.cap == $past(st_ff.pin_s2))
         && (new_res_o == $past(dec_res));
   endsequence
   property p_capture;
      @(posedge clock_i) disable iff (!rstn_i)
      rise |=> s_word_taken;
   endproperty
   a_capture: assert property (p_capture) else $error("new word not captured");

   property p_prev;
      @(posedge clock_i) disable iff (!rstn_i)
      fall |=> prev_o == $past(st_ff.pin_s2);
   endproperty
   a_prev: assert property (p_prev) else $error("previous word not captured");

   property p_range;
      @(posedge clock_i) disable iff (!rstn_i)
      new_valid_o |-> (new_res_o.range == ARF_IN_RANGE) == !st_ff.cap.flag;
   endproperty
   a_range: assert property (p_range) else $error("range decode wrong");

   property p_twos;
      @(posedge clock_i) disable iff (!rstn_i)
      new_valid_o |-> new_res_o.twos[`ARF_RES_W-1] == st_ff.cap.top_n;
   endproperty
   a_twos: assert property (p_twos) else $error("twos top bit wrong");

   property p_signed;
      @(posedge clock_i) disable iff (!rstn_i)
      new_valid_o && st_ff.cap.bits == `ARF_MID_CODE |-> new_res_o.signed_val == 0;
   endproperty
   a_signed: assert property (p_signed) else $error("mid code not zero");

   property p_wait_ends;
      @(posedge clock_i) disable iff (!rstn_i)
      (st_ff.state == ST_WAIT) && rise |=> st_ff.state == ST_IDLE;
   endproperty
   a_wait_ends: assert property (p_wait_ends) else $error("strobe did not end wait");

   property p_no_retrig;
      @(posedge clock_i) disable iff (!rstn_i)
      (st_ff.state == ST_WAIT) |-> !conversion_trigger_o;
   endproperty
   a_no_retrig: assert property (p_no_retrig) else $error("trigger while waiting");

   property p_start_taken;
      @(posedge clock_i) disable iff (!rstn_i)
      (st_ff.state == ST_IDLE) && start_i |=> busy_o && conversion_trigger_o;
   endproperty
   a_start_taken: assert property (p_start_taken) else $error("start not taken");

   property p_timeout;
      @(posedge clock_i) disable iff (!rstn_i)
      (st_ff.state == ST_WAIT) && !rise && (st_ff.wcnt >= TIMEOUT) |=> timeout_o && !busy_o;
   endproperty
   a_timeout: assert property (p_timeout) else $error("missing strobe not reported");
endmodule

/* File: core/arf_cfg.svh */
// Constants for the range-flag result capture controller
// Assumes inclusion by core design files only
`ifndef ARF_CFG_SVH
`define ARF_CFG_SVH
`define ARF_RES_W      12
`define ARF_MID_CODE   12'h800
`define ARF_TRIG_NS    20
`define ARF_CLK_NS     10
`define ARF_TRIG_CYC   ((`ARF_TRIG_NS + `ARF_CLK_NS - 1) / `ARF_CLK_NS)
`define ARF_TIMEOUT    16'h0100
`endif

/* File: core/arf_pkg.sv */
// Types for the range-flag result capture controller
// Assumes arf_cfg.svh supplies all numeric constants
`include "arf_cfg.svh"
package arf_pkg;
   typedef enum logic [1:0]
   {
      ARF_IN_RANGE  = 2'h0,
      ARF_UNDER     = 2'h1,
      ARF_OVER      = 2'h2
   } arf_range_t;
   typedef struct packed
   {
      logic [`ARF_RES_W-1:0] bits;
      logic                  top_n;
      logic                  flag;
   } arf_pins_t;
   typedef struct packed
   {
      logic [`ARF_RES_W-1:0] straight;
      logic [`ARF_RES_W-1:0] twos;
      logic signed [`ARF_RES_W-1:0] signed_val;
      arf_range_t            range;
   } arf_result_t;
endpackage

/* File: core/arf_decode.sv */
// Result decoder: latched pin word into codings and range class
// Assumes inputs are stable registered values on the same clock
`timescale 1ns/1ps
`include "arf_cfg.svh"
module arf_decode
   import arf_pkg::*;
(
   input  wire arf_pkg::arf_pins_t   pins_i,
   output arf_pkg::arf_result_t      res_o
);
   import arf_pkg::*;
   always_comb
   begin
      res_o.straight   = pins_i.bits;
      // Twos complement from the inverted top bit
      res_o.twos       = {pins_i.top_n, pins_i.bits[`ARF_RES_W-2:0]};
      // Straight binary with bipolar input: remove mid code
      res_o.signed_val = $signed(pins_i.bits - `ARF_MID_CODE);
      if (!pins_i.flag)
         res_o.range = ARF_IN_RANGE;
      else if (pins_i.bits[`ARF_RES_W-1])
         res_o.range = ARF_OVER;
      else
         res_o.range = ARF_UNDER;
   end
endmodule

/* File: bench/arf_adc_model.sv */
// Behavioural converter answering each trigger with one coded result
// Assumes ain_i is the ideal code; below 0 or above 4095 is out of range
`timescale 1ns/1ps
module arf_adc_model
(
   input  wire logic               trig_i,
   input  wire logic signed [13:0] ain_i,
   input  wire logic [31:0]        lat_i,
   output logic                    strobe_o,
   output logic [11:0]             bits_o,
   output logic                    top_n_o,
   output logic                    flag_o
);
   initial
   begin
      strobe_o = 1'b0;
      bits_o   = 12'h000;
      top_n_o  = 1'b1;
      flag_o   = 1'b0;
   end
   // Strobe falls at trigger; old word stays until the new one lands
   always @(posedge trig_i)
   begin
      strobe_o = 1'b0;
      #(lat_i);
      flag_o  = (ain_i < 0) || (ain_i > 4095);
      bits_o  = (ain_i < 0) ? 12'h000 : (ain_i > 4095) ? 12'hFFF : ain_i[11:0];
      top_n_o = ~bits_o[11];
      #40 strobe_o = 1'b1;
   end
endmodule

/* File: bench/test_adc_result_format_and_range_flag.sv */
// Bench for the host capture controller against a converter model
// Assumes the model answers every trigger; prompt, slow and late latencies
`timescale 1ns/1ps
module test_adc_result_format_and_range_flag;
   import arf_pkg::*;
   logic               clock_i = 1'b0;
   logic               rstn_i  = 1'b0;
   logic               start_i = 1'b0;
   logic               strobe, top_n, flag, trig, busy, nvalid, tout;
   logic [11:0]        bits;
   logic [11:0]        last;
   arf_result_t        res;
   arf_pins_t          prev;
   logic signed [13:0] ain = 14'h0000;
   int                 lat = 50;
   int                 fails = 0;
   int                 num_checks = 0;
   int                 cyc = 0;
   int                 n_trig = 0;
   int                 n_conv = 0;
   bit                 have_last = 0;
   logic [31:0]        seed = 32'h4D0D;
   arf_result_t        exp_q[$];
   logic signed [13:0] codes[7] = '{-1, 0, 2048, 4095, 4096, 4096, 2047};
   always #5 clock_i = ~clock_i;
   arf_host #(.TRIG_CYC(2), .TIMEOUT(16'h0100)) dut (.clock_i(clock_i), .rstn_i(rstn_i),
      .start_i(start_i), .result_valid_strobe_i(strobe), .data_i(bits),
      .data_top_n_i(top_n), .range_violation_flag_i(flag), .conversion_trigger_o(trig),
      .busy_o(busy), .new_valid_o(nvalid), .new_res_o(res), .prev_o(prev), .timeout_o(tout));
   always @(posedge trig) n_trig++;
   arf_adc_model dev (.trig_i(trig), .ain_i(ain), .lat_i(lat), .strobe_o(strobe),
      .bits_o(bits), .top_n_o(top_n), .flag_o(flag));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp_v);
      num_checks++;
      if (seen !== exp_v)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp_v);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Start held 3 cycles so a retrigger while busy would show
   task automatic conv_one(input logic signed [13:0] a);
      logic [11:0] s;
      arf_result_t e;
      s = (a < 0) ? 12'h000 : (a > 4095) ? 12'hFFF : a[11:0];
      e.straight   = s;
      e.twos       = {~s[11], s[10:0]};
      e.signed_val = s - 12'h800;
      e.range      = (a < 0) ? ARF_UNDER : (a > 4095) ? ARF_OVER : ARF_IN_RANGE;
      exp_q.push_back(e);
      n_conv++;
      ain     <= a;
      start_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      start_i <= 1'b0;
      do @(posedge clock_i); while (busy !== 1'b0);
      repeat (6) @(posedge clock_i);
   endtask
   always @(negedge clock_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         give_verdict();
      end
      if (nvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk(64'h1, 64'h0);
         else
         begin
            chk(res, exp_q[0]);
            if (have_last)
               chk({prev.top_n, prev.bits}, {~last[11], last});
            last = exp_q[0].straight;
            have_last = 1;
            void'(exp_q.pop_front());
         end
      end
   end
   initial
   begin
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      foreach (codes[i])
         conv_one(codes[i]);
      $display("test fixed codes done");
      // Strobe arrives well after the wait limit; late word still captured
      lat = 3000;
      conv_one(14'sh0064);
      @(negedge clock_i);
      chk(tout, 1'b1);
      repeat (60) @(posedge clock_i);
      lat = 50;
      conv_one(14'sh0001);
      @(negedge clock_i);
      chk(tout, 1'b0);
      @(posedge clock_i);
      $display("test missing strobe done");
      lat = 900;
      repeat (6)
      begin
         seed = xs(seed);
         conv_one(seed % 4098 - 1);
      end
      $display("test random slow codes done");
      chk(exp_q.size(), 0);
      chk(n_trig, n_conv);
      give_verdict();
   end
endmodule
